// ===== stk_consts.svh
// Constants of the serial timekeeper: command fields, register map, reset values, limits.
`ifndef STK_CONSTS_SVH
`define STK_CONSTS_SVH
`define STK_CMD_VALID_BIT   7
`define STK_CMD_SPACE_BIT   6
`define STK_CMD_RD_BIT      0
`define STK_BURST_ADDR      5'h1F
`define STK_CLK_REGS        5'h08
`define STK_RAM_BYTES       5'h18
`define STK_SECONDS_REG     3'h0
`define STK_MINUTES_REG     3'h1
`define STK_HOURS_REG       3'h2
`define STK_DATE_REG        3'h3
`define STK_MONTH_REG       3'h4
`define STK_DAY_REG         3'h5
`define STK_YEAR_REG        3'h6
`define STK_CONTROL_REG     3'h7
`define STK_HALT_BIT        7
`define STK_H12_BIT         7
`define STK_PM_BIT          5
`define STK_WP_BIT          7
`define STK_SEC_RST         8'h00
`define STK_MIN_RST         8'h00
`define STK_HOUR_RST        8'h00
`define STK_DATE_RST        8'h01
`define STK_MONTH_RST       8'h01
`define STK_DAY_RST         8'h01
`define STK_YEAR_RST        8'h00
`define STK_CTRL_RST        8'h00
`define STK_SEC_MAX         8'h59
`define STK_H24_MAX         8'h23
`define STK_H12_MAX         8'h12
`define STK_H12_PRE         8'h11
`define STK_MONTH_MAX       8'h12
`define STK_DAY_MAX         8'h07
`define STK_YEAR_MAX        8'h99
`define STK_FEB             8'h02
`define STK_XTAL_HZ         32768
`define STK_FIFO_DEPTH      32
`define STK_ENTRY_W         15
`endif

// ===== stk_pkg.sv
// Types shared by the serial timekeeper modules.
package stk_pkg;
    typedef enum logic [1:0] {
        STK_IDLE  = 2'h0,
        STK_CMD   = 2'h1,
        STK_XFER  = 2'h3,
        STK_ABORT = 2'h2
    } stk_state_e;
    typedef enum logic [1:0] {
        STK_K_RAM    = 2'h0,
        STK_K_CLK    = 2'h1,
        STK_K_STAGE  = 2'h2,
        STK_K_COMMIT = 2'h3
    } stk_kind_e;
    typedef logic [7:0] stk_byte_t;
endpackage

// ===== stk_ram.sv
// Scratch RAM of the serial timekeeper with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module stk_ram #(
    parameter int DEPTH = 24,
    parameter int AW    = 5
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              we,
    input  wire logic [AW-1:0]     waddr,
    input  wire stk_pkg::stk_byte_t wdata,
    input  wire logic [AW-1:0]     raddr,
    output var  stk_pkg::stk_byte_t rdata
);
    import stk_pkg::*;

    generate if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
        $error("stk_ram: DEPTH does not fit the address width");
    end endgenerate

    stk_byte_t mem_ff [DEPTH];
    stk_byte_t rdata_ff;

    // Storage clears on reset so a read before any write is defined.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) mem_ff[i] <= 8'h00;
        end else if (we && waddr < AW'(DEPTH)) begin
            mem_ff[waddr] <= wdata;
        end
    end

    // Out-of-range reads return zero rather than wrapping.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rdata_ff <= 8'h00;
        else     rdata_ff <= (raddr < AW'(DEPTH)) ? mem_ff[raddr] : 8'h00;
    end

    assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ===== stk_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module stk_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("stk_fifo: DEPTH must be a power of two of at least two");
    end endgenerate

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      cnt_ff;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk) begin
        if (push) mem_ff[wr_ptr_ff] <= in_data;
    end

    // Pointers wrap naturally because the depth is a power of two.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + AW'(push);
            rd_ptr_ff <= rd_ptr_ff + AW'(pop);
            cnt_ff    <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ===== stk_top.sv
// Serial timekeeper: three-wire link, BCD clock/calendar, write protect and scratch RAM.
`timescale 1ns/100ps
`default_nettype none
`include "stk_consts.svh"

// Functional notes
// - After enable rises, an eight-bit command picks location, direction and burst.
// - Command bit 7 low aborts the transaction until enable drops.
// - Command bit 6 picks calendar registers (0) or scratch RAM (1).
// - Bits 1-5 are the address; bit 0 high reads, low writes.
// - Command byte arrives least significant bit first.
// - Inputs sampled on rising link clock, outputs changed on falling.
// - Enable low ends any transfer and releases the data line.
// - Write data is the next eight rising bits; extra clocks ignored.
// - Read drives bit 0 on first falling edge after the command.
// - Reads keep producing bytes while enable stays high.
// - Address 31 means burst within the chosen space.
// - No storage at calendar 8-31 or RAM 24-31.
// - Calendar burst write updates registers only after all eight bytes.
// - RAM burst write stores every completed byte at once.
// - Time and date registers hold BCD values.
// - Date rolls at each month end, honouring short months and leap years.
// - Seconds bit 7 halts the timebase; clearing it restarts counting.
// - Hours bit 7 picks 12-hour mode; bit 5 is PM or twenties digit.
// - Control bit 7 write-protects all others; its low bits read zero.
// - Bursts run from address 0 upward through the space.
module stk_top #(
    parameter int XTAL_DIV   = `STK_XTAL_HZ,
    parameter int FIFO_DEPTH = `STK_FIFO_DEPTH
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce_pin,
    input  wire logic sclk_pin,
    input  wire logic io_in,
    input  wire logic xtal_pin,
    output var  logic io_out,
    output var  logic io_oe_n
);
    import stk_pkg::*;

    localparam int DIV_W   = $clog2(XTAL_DIV);
    localparam int PIN_CE  = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_IO  = 2;
    localparam int PIN_XT  = 3;

    generate if (XTAL_DIV < 2 || FIFO_DEPTH < 2) begin : g_chk
        $error("stk_top: XTAL_DIV and FIFO_DEPTH must be at least two");
    end endgenerate

    // BCD increment with wrap: returns {carry, next}.
    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] max,
                                            input logic [7:0] min);
        logic [8:0] r;
        if (v >= max)            r = {1'b1, min};
        else if (v[3:0] == 4'h9) r = {1'b0, v[7:4] + 4'h1, 4'h0};
        else                     r = {1'b0, v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction

    // Hour increment in either format: returns {day carry, next}.
    function automatic logic [8:0] hour_step(input logic [7:0] v);
        logic [8:0] s;
        logic [8:0] r;
        if (v[`STK_H12_BIT]) begin
            s = bcd_step({3'h0, v[4:0]}, `STK_H12_MAX, 8'h01);
            if ({3'h0, v[4:0]} == `STK_H12_PRE)
                r = {v[`STK_PM_BIT], v[7:6], ~v[`STK_PM_BIT], s[4:0]};
            else
                r = {1'b0, v[7:5], s[4:0]};
        end else begin
            s = bcd_step({2'h0, v[5:0]}, `STK_H24_MAX, 8'h00);
            r = {s[8], 2'h0, s[5:0]};
        end
        return r;
    endfunction

    // Last date of the month in BCD, with the four-year leap rule on BCD years.
    function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            `STK_FEB:                      month_end = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11:    month_end = 8'h30;
            default:                       month_end = 8'h31;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [3:0] s3_ff;
    logic [3:0] stb_ff;
    wire  [3:0] pin_raw = {xtal_pin, io_in, sclk_pin, ce_pin};
    wire  [3:0] agree   = ~(s2_ff ^ s3_ff);
    wire  [3:0] nxt_stb = (agree & s3_ff) | (~agree & stb_ff);
    wire  [3:0] pin_rise = nxt_stb & ~stb_ff;
    wire  [3:0] pin_fall = ~nxt_stb & stb_ff;

    // A level counts only when the second and third stages agree; stage one feeds
    // nothing but stage two so a metastable sample never reaches the decoders.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_ff  <= 4'h0;
            s2_ff  <= 4'h0;
            s3_ff  <= 4'h0;
            stb_ff <= 4'h0;
        end else begin
            s1_ff  <= pin_raw;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            stb_ff <= nxt_stb;
        end
    end

    wire ce_hi  = nxt_stb[PIN_CE];
    wire io_val = nxt_stb[PIN_IO];
    wire rise   = pin_rise[PIN_SCK];
    wire fall   = pin_fall[PIN_SCK];

    ////////////////////////////////////////////////////////////////////////////////
    // Link state and decode.

    stk_state_e st_ff;
    stk_state_e nxt_st;
    logic [7:0]  sh_ff;
    logic [2:0]  bit_ff;
    logic [7:0]  cmd_ff;
    logic [4:0]  addr_ff;
    logic        done_ff;
    logic [6:0]  osh_ff;
    logic        io_out_ff;
    logic        io_oe_n_ff;
    logic        push_vld_ff;
    logic [`STK_ENTRY_W-1:0] push_ent_ff;
    stk_byte_t   clk_ff [8];
    stk_byte_t   ram_rdata;
    logic        fifo_in_ready;

    wire [7:0] byte_in   = {io_val, sh_ff[7:1]};
    wire       last_bit  = (bit_ff == 3'h7);
    wire       cmd_rd    = cmd_ff[`STK_CMD_RD_BIT];
    wire       cmd_ram   = cmd_ff[`STK_CMD_SPACE_BIT];
    wire       cmd_burst = (cmd_ff[5:1] == `STK_BURST_ADDR);
    wire       in_burst  = (byte_in[5:1] == `STK_BURST_ADDR);
    wire [4:0] lim       = cmd_ram ? `STK_RAM_BYTES : `STK_CLK_REGS;
    wire       addr_last = (addr_ff == lim - 5'h01);
    wire [4:0] addr_nxt  = addr_last ? 5'h00 : addr_ff + 5'h01;
    wire       cmd_rise  = (st_ff == STK_CMD) & rise;
    wire       cmd_end   = cmd_rise & last_bit;
    wire       wr_rise   = (st_ff == STK_XFER) & ~cmd_rd & ~done_ff & rise;
    wire       wr_end    = wr_rise & last_bit;
    wire       rd_fall   = (st_ff == STK_XFER) & cmd_rd & fall;
    wire       rd_end    = rd_fall & last_bit;

    // Read source; unbacked locations answer zero.
    wire [7:0] clk_rd  = (addr_ff < `STK_CLK_REGS) ? clk_ff[addr_ff[2:0]] : 8'h00;
    wire [7:0] rd_byte = cmd_ram ? ram_rdata : clk_rd;

    // Calendar bursts stage bytes and commit on the last one.
    wire stk_kind_e kind_w = cmd_ram ? STK_K_RAM :
                             !cmd_burst ? STK_K_CLK :
                             (addr_ff == 5'({2'h0, `STK_CONTROL_REG})) ? STK_K_COMMIT
                                                                       : STK_K_STAGE;

    // Transaction sequencer; enable low always returns it to idle.
    always_comb begin
        case (st_ff)
            STK_IDLE:  nxt_st = STK_CMD;
            STK_CMD:   nxt_st = !cmd_end ? STK_CMD :
                                byte_in[`STK_CMD_VALID_BIT] ? STK_XFER : STK_ABORT;
            STK_XFER:  nxt_st = STK_XFER;
            STK_ABORT: nxt_st = STK_ABORT;
            default:   nxt_st = STK_IDLE;
        endcase
        if (!ce_hi) nxt_st = STK_IDLE;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) st_ff <= STK_IDLE;
        else     st_ff <= nxt_st;
    end

    // Shift register and bit counter start fresh for every enable period.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sh_ff  <= 8'h00;
            bit_ff <= 3'h0;
        end else if (!ce_hi) begin
            sh_ff  <= 8'h00;
            bit_ff <= 3'h0;
        end else begin
            if (cmd_rise || wr_rise) sh_ff <= byte_in;
            if (cmd_rise || wr_rise || rd_fall) bit_ff <= bit_ff + 3'h1;
        end
    end

    // Command, address and write completion tracking.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd_ff  <= 8'h00;
            addr_ff <= 5'h00;
            done_ff <= 1'b0;
        end else if (!ce_hi) begin
            cmd_ff  <= 8'h00;
            addr_ff <= 5'h00;
            done_ff <= 1'b0;
        end else begin
            if (cmd_end) cmd_ff <= byte_in;
            if (cmd_end) addr_ff <= in_burst ? 5'h00 : byte_in[5:1];
            else if ((wr_end || rd_end) && cmd_burst) addr_ff <= addr_nxt;
            if (wr_end && (!cmd_burst || addr_last)) done_ff <= 1'b1;
        end
    end

    // Data pin: driven only during a read, bit 0 first, released when enable drops.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            io_out_ff  <= 1'b0;
            io_oe_n_ff <= 1'b1;
            osh_ff     <= 7'h00;
        end else if (!ce_hi) begin
            io_out_ff  <= 1'b0;
            io_oe_n_ff <= 1'b1;
            osh_ff     <= 7'h00;
        end else if (rd_fall) begin
            io_oe_n_ff <= 1'b0;
            io_out_ff  <= (bit_ff == 3'h0) ? rd_byte[0] : osh_ff[0];
            osh_ff     <= (bit_ff == 3'h0) ? rd_byte[7:1] : {1'b0, osh_ff[6:1]};
        end
    end

    // Completed write bytes wait here until the FIFO accepts them.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            push_vld_ff <= 1'b0;
            push_ent_ff <= '0;
        end else if (wr_end) begin
            push_vld_ff <= 1'b1;
            push_ent_ff <= {kind_w, addr_ff, byte_in};
        end else if (fifo_in_ready) begin
            push_vld_ff <= 1'b0;
        end
    end

    assign io_out  = io_out_ff;
    assign io_oe_n = io_oe_n_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Write FIFO and commit side.

    logic                    fifo_out_valid;
    logic [`STK_ENTRY_W-1:0] fifo_out_data;
    logic                    tick_ff;

    // The drain pauses on a timebase tick so a register never sees two writers.
    wire fifo_out_ready = ~tick_ff;

    stk_fifo #(
        .WIDTH (`STK_ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst       (rst),
        .in_valid  (push_vld_ff),
        .in_ready  (fifo_in_ready),
        .in_data   (push_ent_ff),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    wire            pop     = fifo_out_valid & fifo_out_ready;
    wire stk_kind_e d_kind  = stk_kind_e'(fifo_out_data[14:13]);
    wire [4:0]      d_addr  = fifo_out_data[12:8];
    wire [7:0]      d_byte  = fifo_out_data[7:0];
    wire            wp      = clk_ff[`STK_CONTROL_REG][`STK_WP_BIT];
    wire            ram_we  = pop & (d_kind == STK_K_RAM) & ~wp;
    wire            clk_one = pop & (d_kind == STK_K_CLK);
    wire            stage   = pop & (d_kind == STK_K_STAGE);
    wire            commit  = pop & (d_kind == STK_K_COMMIT);

    stk_ram #(
        .DEPTH (`STK_RAM_BYTES),
        .AW    (5)
    ) u_ram (
        .clk   (core_clk),
        .rst   (rst),
        .we    (ram_we),
        .waddr (d_addr),
        .wdata (d_byte),
        .raddr (addr_ff),
        .rdata (ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Timebase and BCD calendar.

    logic [DIV_W-1:0] div_ff;
    wire              halt   = clk_ff[`STK_SECONDS_REG][`STK_HALT_BIT];
    wire              xt_rise = pin_rise[PIN_XT] & ~halt;
    wire              div_end = (div_ff == DIV_W'(XTAL_DIV - 1));

    // One tick per second of crystal edges; the halt flag freezes the divider.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= xt_rise & div_end;
            if (xt_rise) div_ff <= div_end ? '0 : div_ff + DIV_W'(1);
        end
    end

    wire [8:0] sec_s  = bcd_step({1'b0, clk_ff[0][6:0]}, `STK_SEC_MAX, 8'h00);
    wire [8:0] min_s  = bcd_step(clk_ff[1], `STK_SEC_MAX, 8'h00);
    wire [8:0] hour_s = hour_step(clk_ff[2]);
    wire [8:0] date_s = bcd_step(clk_ff[3], month_end(clk_ff[4], clk_ff[6]), 8'h01);
    wire [8:0] mon_s  = bcd_step(clk_ff[4], `STK_MONTH_MAX, 8'h01);
    wire [8:0] day_s  = bcd_step(clk_ff[5], `STK_DAY_MAX, 8'h01);
    wire [8:0] year_s = bcd_step(clk_ff[6], `STK_YEAR_MAX, 8'h00);
    wire       c_min  = sec_s[8];
    wire       c_hour = c_min & min_s[8];
    wire       c_day  = c_hour & hour_s[8];
    wire       c_mon  = c_day & date_s[8];
    wire       c_year = c_mon & mon_s[8];

    stk_byte_t tick_val [8];
    stk_byte_t shadow_ff [7];
    assign tick_val[0] = {clk_ff[0][7], sec_s[6:0]};
    assign tick_val[1] = c_min  ? min_s[7:0]  : clk_ff[1];
    assign tick_val[2] = c_hour ? hour_s[7:0] : clk_ff[2];
    assign tick_val[3] = c_day  ? date_s[7:0] : clk_ff[3];
    assign tick_val[4] = c_mon  ? mon_s[7:0]  : clk_ff[4];
    assign tick_val[5] = c_day  ? day_s[7:0]  : clk_ff[5];
    assign tick_val[6] = c_year ? year_s[7:0] : clk_ff[6];
    assign tick_val[7] = clk_ff[7];

    localparam stk_byte_t RST_VAL [8] = '{`STK_SEC_RST, `STK_MIN_RST, `STK_HOUR_RST,
        `STK_DATE_RST, `STK_MONTH_RST, `STK_DAY_RST, `STK_YEAR_RST, `STK_CTRL_RST};

    // One register per calendar slot; the control slot keeps only its protect bit.
    generate for (genvar i = 0; i < 8; i++) begin : g_reg
        wire       is_ctl = (i == `STK_CONTROL_REG);
        wire       hit    = clk_one & (d_addr == 5'(i));
        wire       wr     = is_ctl ? (hit | commit)
                                   : ((hit | commit) & ~wp);
        wire [7:0] src    = commit && !is_ctl ? shadow_ff[i % 7] : d_byte;
        wire [7:0] wval   = is_ctl ? {src[`STK_WP_BIT], 7'h00} : src;
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst)                    clk_ff[i] <= RST_VAL[i];
            else if (tick_ff && !is_ctl) clk_ff[i] <= tick_val[i];
            else if (wr)                clk_ff[i] <= wval;
        end
        if (i < 7) begin : g_shadow
            // Burst bytes wait here so a partial burst leaves the time untouched.
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst)                               shadow_ff[i] <= 8'h00;
                else if (stage && d_addr == 5'(i)) shadow_ff[i] <= d_byte;
            end
        end
    end endgenerate
endmodule
`default_nettype wire

// ===== stk_checker.sv
// Checker of the three-wire link pins of the serial timekeeper.
`timescale 1ns/100ps
`default_nettype none
module stk_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce_pin,
    input wire logic sclk_pin,
    input wire logic io_in,
    input wire logic xtal_pin,
    input wire logic io_out,
    input wire logic io_oe_n
);
    logic [7:0] cyc_ff;
    logic [7:0] nxt_cyc;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Cycles since enable rose; it saturates so that a long burst cannot wrap it.
    assign nxt_cyc = !ce_pin ? 8'h00 : ((cyc_ff == 8'hFF) ? cyc_ff : cyc_ff + 8'h01);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) cyc_ff <= 8'h00;
        else cyc_ff <= nxt_cyc;
    end
    ////////////////////////////////////////////////////////////////////////
    // Enable low long enough for the synchroniser to see it, and the start of driving.
    sequence s_idle;
        !ce_pin [*6];
    endsequence
    sequence s_start;
        $fell(io_oe_n);
    endsequence
    a_release_idle: assert property (s_idle |-> io_oe_n && !io_out)
        else $error("line not released while enable low");
    a_idle_low: assert property (io_oe_n |-> !io_out)
        else $error("output bit set while released");
    a_reset_quiet: assert property ($fell(rst) |-> io_oe_n && !io_out)
        else $error("line driven after reset");
    a_drive_enabled: assert property (!io_oe_n |-> $past(ce_pin, 5))
        else $error("line driven without enable");
    a_change_on_fall: assert property ($changed(io_out) && !io_oe_n |-> !$past(sclk_pin, 2))
        else $error("output bit changed away from falling edge");
    a_first_fall: assert property (s_start |-> !$past(sclk_pin, 2))
        else $error("driving began away from falling edge");
    a_drive_holds: assert property (s_start |-> ##1 !io_oe_n [*3])
        else $error("driving stopped within a bit");
    a_cmd_first: assert property (s_start |-> cyc_ff > 8'h3C)
        else $error("data driven before the command ended");
endmodule
bind stk_top stk_checker u_stk_checker (.core_clk(core_clk), .rst(rst), .ce_pin(ce_pin),
    .sclk_pin(sclk_pin), .io_in(io_in), .xtal_pin(xtal_pin), .io_out(io_out),
    .io_oe_n(io_oe_n));
`default_nettype wire

// ===== stk_host_model.sv
// Host side of the three-wire link: enable, serial clock and data line.
`timescale 1ns/100ps
`default_nettype none
module stk_host_model (
    input  wire logic core_clk,
    output var  logic ce_pin,
    output var  logic sclk_pin,
    output wire logic io_line,
    input  wire logic io_out,
    input  wire logic io_oe_n
);
    import stk_pkg::*;
    stk_byte_t dat_q [0:23];
    logic      hoe;
    logic      hd;
    // The line has a pull-down, so a released line reads low, never a stale bit.
    assign io_line = !io_oe_n ? io_out : (hoe ? hd : 1'b0);
    initial begin
        ce_pin = 1'b0;
        sclk_pin = 1'b0;
        hoe = 1'b0;
        hd = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Half a link clock period, four core cycles, giving a 320 ns period.
    task automatic half();
        repeat (4) @(posedge core_clk);
    endtask
    // One transaction: command then n bytes; bits change only while the clock is low.
    task automatic run(input stk_byte_t cmd, input int n);
        int i;
        ce_pin <= 1'b1;
        half();
        for (i = 0; i < 8 * (n + 1); i++) begin
            hoe <= (i < 8) || !cmd[0];
            hd <= (i < 8) ? cmd[i] : dat_q[i / 8 - 1][i % 8];
            half();
            sclk_pin <= 1'b1;
            half();
            if (i >= 8 && cmd[0]) dat_q[i / 8 - 1][i % 8] = io_line;
            sclk_pin <= 1'b0;
        end
        half();
        ce_pin <= 1'b0;
        hoe <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the serial timekeeper through its three-wire link.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import stk_pkg::*;
    logic core_clk;
    logic rst;
    logic xtal_pin;
    wire  ce_pin;
    wire  sclk_pin;
    wire  io_line;
    wire  io_out;
    wire  io_oe_n;
    int   fail_count;
    int   tests_run;
    stk_top #(.XTAL_DIV(4), .FIFO_DEPTH(32)) u_stk_top (.core_clk(core_clk), .rst(rst),
        .ce_pin(ce_pin), .sclk_pin(sclk_pin), .io_in(io_line), .xtal_pin(xtal_pin),
        .io_out(io_out), .io_oe_n(io_oe_n));
    stk_host_model u_stk_host_model (.core_clk(core_clk), .ce_pin(ce_pin),
        .sclk_pin(sclk_pin), .io_line(io_line), .io_out(io_out), .io_oe_n(io_oe_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input stk_byte_t cmd, input stk_byte_t d[$]);
        foreach (d[k]) u_stk_host_model.dat_q[k] = d[k];
        u_stk_host_model.run(cmd, d.size());
    endtask
    task automatic rd(input stk_byte_t cmd, input stk_byte_t e[$]);
        u_stk_host_model.run(cmd, e.size());
        foreach (e[k]) begin
            tests_run++;
            if (u_stk_host_model.dat_q[k] !== e[k]) begin
                fail_count++;
                $display("wrong value at %0t: cmd %h byte %0d got %h exp %h", $time, cmd, k,
                    u_stk_host_model.dat_q[k], e[k]);
            end
        end
    endtask
    // Crystal edges are slow square waves so the synchroniser sees every one.
    task automatic tick(input int n);
        repeat (n) begin
            xtal_pin <= 1'b1;
            repeat (6) @(posedge core_clk);
            xtal_pin <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
        repeat (8) @(posedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (100000) @(posedge core_clk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        xtal_pin = 1'b0;
        fail_count = 0;
        tests_run = 0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        rd(8'hBF, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00});
        wr(8'h82, '{8'h34, 8'h77});
        rd(8'h83, '{8'h34, 8'h34});
        wr(8'h02, '{8'h22});
        rd(8'h83, '{8'h34});
        wr(8'hCA, '{8'h5A});
        rd(8'hCB, '{8'h5A});
        rd(8'h8B, '{8'h01});
        wr(8'hFE, '{8'hA1, 8'hA2, 8'hA3});
        rd(8'hFF, '{8'hA1, 8'hA2, 8'hA3});
        wr(8'hF0, '{8'h77});
        rd(8'hF1, '{8'h00});
        wr(8'h8E, '{8'hFF});
        rd(8'h8F, '{8'h80});
        wr(8'h82, '{8'h11});
        rd(8'h83, '{8'h34});
        wr(8'h8E, '{8'h00});
        wr(8'hBE, '{8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11});
        rd(8'h83, '{8'h34});
        wr(8'hBE, '{8'hD8, 8'h59, 8'h23, 8'h28, 8'h02, 8'h03, 8'h01, 8'h00});
        tick(8);
        rd(8'hBF, '{8'hD8, 8'h59, 8'h23, 8'h28, 8'h02, 8'h03, 8'h01, 8'h00});
        wr(8'h80, '{8'h58});
        tick(8);
        rd(8'hBF, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h04, 8'h01, 8'h00});
        wr(8'hBE, '{8'h58, 8'h59, 8'hB1, 8'h31, 8'h12, 8'h07, 8'h99, 8'h00});
        tick(8);
        rd(8'hBF, '{8'h00, 8'h00, 8'h92, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00});
        report_and_stop();
    end
endmodule
`default_nettype wire
